// [rtl/wave_sequencer.sv]
`timescale 1ns/1ps
// Segmented waveform sequencer producing setpoints for the output stage.
module wave_sequencer (
    input  wire logic                      ref_clk,
    input  wire logic                      rst,
    input  wire logic                      wave_clear,
    input  wire logic                      mode_sel,
    input  wire logic                      seg_wr,
    input  wire wave_seq_pkg::segment_t    seg_in,
    input  wire wave_seq_pkg::limits_t     lim,
    input  wire logic [9:0]                count_in,
    input  wire logic                      run_start,
    input  wire logic                      run_stop,
    output logic                           seg_ack,
    output logic                           seg_reject,
    output logic [3:0]                     seg_total,
    output logic                           wave_mode,
    output logic                           running,
    output logic                           output_enable,
    output logic signed [23:0]             setpoint,
    output logic                           setpoint_valid
);
    import wave_seq_pkg::*;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } run_state_t;

    typedef struct packed {
        segment_t [9:0]     segs;
        logic [3:0]         nsegs;
        logic [12:0]        pts_total;
        logic               wave_mode;
        run_state_t         run;
        logic               out_en;
        logic [3:0]         idx;
        logic [9:0]         pass;
        logic [9:0]         count;
        logic [11:0]        angle;
        logic [11:0]        end_angle;
        logic [33:0]        ang_acc;
        logic [33:0]        pt_acc;
        logic [27:0]        level_cnt;
        logic               first_pt;
        logic               pt_tick;
        logic signed [23:0] pend_amp;
        logic signed [23:0] pend_off;
        logic               pend_level;
        logic signed [23:0] setpoint;
        logic               sp_valid;
        logic               seg_ack;
        logic               seg_reject;
    } seq_state_t;

    seq_state_t         st;
    seq_state_t         next_st;
    logic signed [15:0] wave;
    segment_t           cur;

    assign cur = st.segs[st.idx];

    wave_shape u_shape (
        .ref_clk (ref_clk),
        .rst     (rst),
        .kind    (cur.kind),
        .angle   (st.angle),
        .wave    (wave)
    );

    function automatic logic angled(input seg_kind_t k);
        return (k == SEG_SINE) || (k == SEG_TRIANGLE);
    endfunction : angled

    // Entry checks against the ranges of each segment type and the limits.
    function automatic logic seg_ok(input segment_t s, input limits_t l);
        logic rate_ok;
        logic lvl_ok;
        unique case (s.kind)
            SEG_SQUARE:   rate_ok = s.rate >= SQ_FREQ_MIN && s.rate <= SQ_FREQ_MAX;
            SEG_POS_RAMP,
            SEG_NEG_RAMP: rate_ok = s.rate >= RAMP_FREQ_MIN && s.rate <= RAMP_FREQ_MAX;
            SEG_TRIANGLE,
            SEG_SINE:     rate_ok = s.rate >= SINE_FREQ_MIN && s.rate <= SINE_FREQ_MAX;
            SEG_LEVEL:    rate_ok = s.rate >= LEVEL_PER_MIN && s.rate <= LEVEL_PER_MAX;
            default:      rate_ok = 1'b0;
        endcase
        lvl_ok = (s.kind == SEG_LEVEL) ||
                 (s.amp >= 0 && 25'(s.amp) <= 25'(l.max) - 25'(l.min));
        return rate_ok && lvl_ok && s.offset <= l.max && s.offset >= l.min &&
               s.start_ang <= ANG_FULL && s.stop_ang <= ANG_FULL &&
               s.points != 12'h000;
    endfunction : seg_ok

    // First segment at or after from that plays; later passes skip initial ones.
    function automatic logic [4:0] first_play(input seq_state_t s, input logic [3:0] from,
                                              input logic later);
        logic [4:0] found;
        found = 5'h10;
        for (int i = 0; i < 10; i++) begin
            if (found[4] && 4'(i) >= from && 4'(i) < s.nsegs &&
                (!later || !s.segs[i].initial_only || 4'(i) == s.nsegs - 4'h1)) begin
                found = 5'(i);
            end
        end
        return found;
    endfunction : first_play

    function automatic seq_state_t load_seg(input seq_state_t s, input logic [3:0] i);
        segment_t c;
        c = s.segs[i];
        s.idx = i;
        s.angle = 12'h000;
        s.end_angle = ANG_FULL;
        if (angled(c.kind)) begin
            s.angle = (c.start_ang == ANG_FULL) ? 12'h000 : c.start_ang;
            s.end_angle = (c.stop_ang == 12'h000) ? ANG_FULL : c.stop_ang;
        end
        s.ang_acc = '0;
        s.pt_acc = '0;
        s.level_cnt = 28'(32'(c.rate) * 32'(CYC_PER_LEVEL_UNIT)) - 28'h1;
        s.first_pt = 1'b1;
        return s;
    endfunction : load_seg

    always_comb begin
        logic [33:0]        ang_sum;
        logic [33:0]        pt_sum;
        logic               tick;
        logic               seg_done;
        logic [4:0]         nidx;
        logic [9:0]         npass;
        logic signed [39:0] prod;
        logic signed [24:0] val;
        next_st = st;
        next_st.seg_ack = 1'b0;
        next_st.seg_reject = 1'b0;
        next_st.sp_valid = 1'b0;
        next_st.pt_tick = 1'b0;
        next_st.first_pt = 1'b0;
        ang_sum = st.ang_acc + 34'(34'(cur.rate) * 34'(ANG_FULL));
        pt_sum = st.pt_acc + 34'(34'(cur.rate) * 34'(cur.points));
        tick = st.first_pt;
        seg_done = 1'b0;
        nidx = 5'h10;
        npass = st.pass;
        // Half the peak-to-peak swing either side of the offset.
        prod = 40'(st.pend_amp) * 40'(wave);
        val = st.pend_level ? 25'(st.pend_off) : 25'(st.pend_off) + 25'(prod >>> 16);
        if (val > 25'(lim.max)) begin
            val = 25'(lim.max);
        end else if (val < 25'(lim.min)) begin
            val = 25'(lim.min);
        end
        if (st.pt_tick && st.run == ST_RUN && !run_stop) begin
            next_st.setpoint = 24'(val);
            next_st.sp_valid = 1'b1;
        end
        unique case (st.run)
            ST_IDLE: begin
                if (seg_wr) begin
                    if (st.nsegs < MAX_SEGS && seg_ok(seg_in, lim) &&
                        st.pts_total + 13'(seg_in.points) <= MAX_POINTS) begin
                        next_st.segs[st.nsegs] = seg_in;
                        next_st.nsegs = st.nsegs + 4'h1;
                        next_st.pts_total = st.pts_total + 13'(seg_in.points);
                        next_st.seg_ack = 1'b1;
                    end else begin
                        next_st.seg_reject = 1'b1;
                    end
                end else if (wave_clear) begin
                    next_st.nsegs = 4'h0;
                    next_st.pts_total = 13'h0000;
                    next_st.wave_mode = mode_sel;
                end else if (run_start && st.nsegs != 4'h0 && count_in <= COUNT_MAX) begin
                    next_st = load_seg(next_st, 4'h0);
                    next_st.run = ST_RUN;
                    next_st.out_en = 1'b1;
                    next_st.pass = 10'h000;
                    next_st.count = count_in;
                end
            end
            ST_RUN: begin
                if (run_stop) begin
                    next_st.run = ST_IDLE;
                    next_st.out_en = 1'b0;
                end else begin
                    if (cur.kind == SEG_LEVEL) begin
                        if (st.level_cnt == 28'h0) begin
                            seg_done = 1'b1;
                        end else begin
                            next_st.level_cnt = st.level_cnt - 28'h1;
                        end
                    end else begin
                        // A phase step of 0.1 degree each time the sum wraps.
                        next_st.ang_acc = ang_sum;
                        next_st.pt_acc = pt_sum;
                        if (ang_sum >= ACC_MOD) begin
                            next_st.ang_acc = ang_sum - ACC_MOD;
                            if (st.angle + 12'h001 == st.end_angle) begin
                                seg_done = 1'b1;
                            end else if (st.angle + 12'h001 == ANG_FULL) begin
                                next_st.angle = 12'h000;
                            end else begin
                                next_st.angle = st.angle + 12'h001;
                            end
                        end
                        if (pt_sum >= ACC_MOD) begin
                            next_st.pt_acc = pt_sum - ACC_MOD;
                            tick = 1'b1;
                        end
                    end
                    if (seg_done) begin
                        nidx = first_play(st, st.idx + 4'h1, st.pass != 10'h000);
                        if (nidx[4]) begin
                            npass = st.pass + 10'h001;
                            nidx = first_play(st, 4'h0, 1'b1);
                        end
                        if (st.count != 10'h000 && npass == st.count) begin
                            next_st.run = ST_IDLE;
                            next_st.out_en = 1'b0;
                        end else begin
                            next_st = load_seg(next_st, nidx[3:0]);
                            next_st.pass = npass;
                        end
                    end
                end
            end
        endcase
        if (tick && st.run == ST_RUN) begin
            next_st.pt_tick = 1'b1;
            next_st.pend_amp = cur.amp;
            next_st.pend_off = cur.offset;
            next_st.pend_level = (cur.kind == SEG_LEVEL);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign seg_ack        = st.seg_ack;
    assign seg_reject     = st.seg_reject;
    assign seg_total      = st.nsegs;
    assign wave_mode      = st.wave_mode;
    assign running        = st.run;
    assign output_enable  = st.out_en;
    assign setpoint       = st.setpoint;
    assign setpoint_valid = st.sp_valid;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    stop_halts_a: assert property (run_stop |=> !output_enable && !running)
        else $error("stop did not halt the sequencer");
    seg_full_a: assert property (seg_wr && !running && seg_total == MAX_SEGS
                                 |=> seg_reject && seg_total == MAX_SEGS)
        else $error("eleventh segment was accepted");
    point_budget_a: assert property (st.pts_total <= MAX_POINTS)
        else $error("point total exceeds budget");
    clamp_range_a: assert property (setpoint_valid |-> setpoint <= $past(lim.max)
                                    && setpoint >= $past(lim.min))
        else $error("setpoint outside software limits");
    mode_fixed_a: assert property (!$past(wave_clear) |-> $stable(wave_mode))
        else $error("waveform mode changed without a new waveform");
    square_freq_a: assert property (seg_wr && !running && seg_in.kind == SEG_SQUARE
                                    && seg_in.rate > SQ_FREQ_MAX |=> seg_reject)
        else $error("square frequency above range accepted");
    level_period_a: assert property (seg_wr && !running && seg_in.kind == SEG_LEVEL
                                     && seg_in.rate < LEVEL_PER_MIN |=> seg_reject)
        else $error("level period below range accepted");
    endless_run_a: assert property ($fell(running) |-> $past(run_stop)
                                    || $past(st.count) != 10'h000)
        else $error("count zero waveform ended by itself");
    level_value_a: assert property (st.pt_tick && st.pend_level && running && !run_stop
                                    && st.pend_off <= lim.max && st.pend_off >= lim.min
                                    |=> setpoint == $past(st.pend_off))
        else $error("level point differs from its offset");

    run_cover_c: cover property (run_start && !running ##1 running);
    stop_cover_c: cover property (running ##1 run_stop);
    pass_cover_c: cover property (running && st.pass == 10'h001);
    reject_cover_c: cover property (seg_reject);

endmodule : wave_sequencer

// [rtl/wave_seq_pkg.sv]
// Operation
// - Square starts with its positive half-cycle.
// - Ramps rise or fall bipolar over each period.
// - Sine, triangle start positive; honour angles.
// - Level holds offset for its programmed period.
// - Level period limited to 0.005..5 seconds.
// - Square frequency limited to 0.02..1000 Hz.
// - Ramp frequency limited to 0.02..532 Hz.
// - Sine, triangle frequency limited to 0.01..443 Hz.
// - Amplitude is peak-to-peak in waveform's unit.
// - Out-of-limit amplitude or offset refused on entry.
// - Non-level segments swing centred on offset.
// - Output clamped to active software limits.
// - Start angle 0..360 degrees, default zero.
// - Stop angle zero means full 360 degrees.
// - Repeating segments play on every pass.
// - Initial segments play on first pass only.
// - Last segment always plays as repeating.
// - Stop halts at once, output to standby.
// - Waveform mode fixed once the waveform exists.
// - Count zero repeats until stopped.
// - One to ten segments per waveform.
// - Point total above 3933 refused.
package wave_seq_pkg;

    typedef enum logic [2:0] {
        SEG_SQUARE   = 3'h0,
        SEG_POS_RAMP = 3'h1,
        SEG_NEG_RAMP = 3'h2,
        SEG_TRIANGLE = 3'h3,
        SEG_SINE     = 3'h4,
        SEG_LEVEL    = 3'h5
    } seg_kind_t;

    // Rate is in 0.01 Hz for periodic segments and in 0.1 ms for a level.
    typedef struct packed {
        seg_kind_t          kind;
        logic               initial_only;
        logic [16:0]        rate;
        logic signed [23:0] amp;
        logic signed [23:0] offset;
        logic [11:0]        start_ang;
        logic [11:0]        stop_ang;
        logic [11:0]        points;
    } segment_t;

    typedef struct packed {
        logic signed [23:0] max;
        logic signed [23:0] min;
    } limits_t;

    localparam int          CLK_HZ             = 50_000_000;
    localparam int          CLK_PERIOD_NS      = 20;
    localparam int          FREQ_SCALE         = 100;
    localparam logic [33:0] ACC_MOD            = 34'(64'(CLK_HZ) * 64'(FREQ_SCALE));
    localparam int          LEVEL_UNIT_NS      = 100_000;
    localparam int          CYC_PER_LEVEL_UNIT = LEVEL_UNIT_NS / CLK_PERIOD_NS;

    localparam logic [16:0] SQ_FREQ_MIN   = 17'h00002;
    localparam logic [16:0] SQ_FREQ_MAX   = 17'h186a0;
    localparam logic [16:0] RAMP_FREQ_MIN = 17'h00002;
    localparam logic [16:0] RAMP_FREQ_MAX = 17'h0cfd0;
    localparam logic [16:0] SINE_FREQ_MIN = 17'h00001;
    localparam logic [16:0] SINE_FREQ_MAX = 17'h0ad0c;
    localparam logic [16:0] LEVEL_PER_MIN = 17'h00032;
    localparam logic [16:0] LEVEL_PER_MAX = 17'h0c350;

    localparam logic [11:0] ANG_QUARTER = 12'h384;
    localparam logic [11:0] ANG_HALF    = 12'h708;
    localparam logic [11:0] ANG_3Q      = 12'ha8c;
    localparam logic [11:0] ANG_FULL    = 12'he10;

    localparam logic [3:0]  MAX_SEGS   = 4'ha;
    localparam logic [12:0] MAX_POINTS = 13'h0f5d;
    localparam logic [9:0]  COUNT_MAX  = 10'h3e7;

    localparam logic [15:0] FULL_SCALE = 16'h7fff;
    localparam logic [6:0]  SINE_MUL   = 7'h49;
    localparam int          SINE_SHIFT = 12;
    localparam logic [15:0] TRI_MUL    = 16'h91a2;
    localparam int          TRI_SHIFT  = 10;
    localparam logic [13:0] RAMP_MUL   = 14'h2468;
    localparam int          RAMP_SHIFT = 9;

    localparam logic [15:0] SINE_Q [17] = '{
        16'h0000, 16'h0c8c, 16'h18f9, 16'h2528, 16'h30fb, 16'h3c56,
        16'h471c, 16'h5133, 16'h5a82, 16'h62f1, 16'h6a6d, 16'h70e2,
        16'h7641, 16'h7a7c, 16'h7d89, 16'h7f61, 16'h7fff
    };

endpackage : wave_seq_pkg

// [rtl/wave_shape.sv]
`timescale 1ns/1ps
// Unit waveform from a phase in tenths of a degree, one cycle of latency.
module wave_shape (
    input  wire logic                      ref_clk,
    input  wire logic                      rst,
    input  wire wave_seq_pkg::seg_kind_t   kind,
    input  wire logic [11:0]               angle,
    output logic signed [15:0]             wave
);
    import wave_seq_pkg::*;

    typedef struct packed {
        logic signed [15:0] wave;
    } shape_state_t;

    shape_state_t st;
    shape_state_t next_st;

    always_comb begin
        logic [11:0] r;
        logic [11:0] m;
        logic        neg;
        logic [15:0] mag;
        logic [31:0] prod;
        r = angle;
        neg = 1'b0;
        if (angle >= ANG_3Q) begin
            r = angle - ANG_3Q;
            neg = 1'b1;
        end else if (angle >= ANG_HALF) begin
            r = angle - ANG_HALF;
            neg = 1'b1;
        end else if (angle >= ANG_QUARTER) begin
            r = angle - ANG_QUARTER;
        end
        // Odd quadrants run back down towards zero.
        m = ((angle >= ANG_QUARTER && angle < ANG_HALF) || angle >= ANG_3Q)
            ? ANG_QUARTER - r : r;
        mag = 16'h0000;
        prod = 32'h0;
        unique case (kind)
            SEG_SQUARE: begin
                mag = FULL_SCALE;
                neg = (angle >= ANG_HALF);
            end
            SEG_POS_RAMP, SEG_NEG_RAMP: begin
                prod = 32'(angle) * 32'(RAMP_MUL);
                mag = 16'(prod >> RAMP_SHIFT);
                neg = 1'b0;
            end
            SEG_TRIANGLE: begin
                prod = 32'(m) * 32'(TRI_MUL);
                mag = 16'(prod >> TRI_SHIFT);
            end
            SEG_SINE: begin
                prod = 32'(m) * 32'(SINE_MUL);
                mag = SINE_Q[5'(prod >> SINE_SHIFT)];
            end
            SEG_LEVEL: begin
                neg = 1'b0;
            end
            default: begin
                neg = 1'b0;
            end
        endcase
        next_st.wave = neg ? -$signed(mag) : $signed(mag);
        if (kind == SEG_POS_RAMP) begin
            next_st.wave = $signed(mag - FULL_SCALE);
        end else if (kind == SEG_NEG_RAMP) begin
            next_st.wave = $signed(FULL_SCALE - mag);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign wave = st.wave;

endmodule : wave_shape

// [tb/setpoint_sink.sv]
`timescale 1ns/1ps
// Output stage model: holds the last point while enabled, sits at zero in standby.
module setpoint_sink (
    input  wire logic               ref_clk,
    input  wire logic               rst,
    input  wire logic               output_enable,
    input  wire logic signed [23:0] setpoint,
    input  wire logic               setpoint_valid,
    output logic signed [23:0]      applied
);
    logic signed [23:0] held;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            held <= '0;
        end else if (setpoint_valid) begin
            held <= setpoint;
        end
    end
    // Standby drops the output at once, whatever point was held.
    assign applied = output_enable ? held : 24'h000000;
endmodule : setpoint_sink

// [tb/waveform_segment_sequencer_test.sv]
`timescale 1ns/1ps
module waveform_segment_sequencer_test;
    import wave_seq_pkg::*;
    logic               ref_clk = 1'b0;
    logic               rst = 1'b1;
    logic               wave_clear = 1'b0;
    logic               mode_sel = 1'b0;
    logic               seg_wr = 1'b0;
    segment_t           seg_in = '0;
    limits_t            lim = '{24'h0003e8, 24'hfffc18};
    logic [9:0]         count_in = 10'h001;
    logic               run_start = 1'b0;
    logic               run_stop = 1'b0;
    logic               seg_ack, seg_reject, wave_mode, running, output_enable, setpoint_valid;
    logic [3:0]         seg_total;
    logic signed [23:0] setpoint, applied, off, amp, exp_v;
    int                 n, pts;
    segment_t           s0, s1;
    int                 err_total = 0;
    int                 compares = 0;
    logic [16:0]        lo [6] = '{SQ_FREQ_MIN, RAMP_FREQ_MIN, RAMP_FREQ_MIN,
                                   SINE_FREQ_MIN, SINE_FREQ_MIN, LEVEL_PER_MIN};
    logic [16:0]        hi [6] = '{SQ_FREQ_MAX, RAMP_FREQ_MAX, RAMP_FREQ_MAX,
                                   SINE_FREQ_MAX, SINE_FREQ_MAX, LEVEL_PER_MAX};

    always #10 ref_clk = ~ref_clk;

    wave_sequencer i_wave_sequencer (.ref_clk(ref_clk), .rst(rst), .wave_clear(wave_clear),
        .mode_sel(mode_sel), .seg_wr(seg_wr), .seg_in(seg_in), .lim(lim), .count_in(count_in),
        .run_start(run_start), .run_stop(run_stop), .seg_ack(seg_ack), .seg_reject(seg_reject),
        .seg_total(seg_total), .wave_mode(wave_mode), .running(running),
        .output_enable(output_enable), .setpoint(setpoint), .setpoint_valid(setpoint_valid));
    setpoint_sink i_setpoint_sink (.ref_clk(ref_clk), .rst(rst), .output_enable(output_enable),
        .setpoint(setpoint), .setpoint_valid(setpoint_valid), .applied(applied));

    task automatic end_sim();
        $display("compares %0d, err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %0h, seen %0h", name, exp, seen);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    function automatic segment_t mk(input int k, input logic [16:0] r,
                                    input logic signed [23:0] a, input logic signed [23:0] o,
                                    input logic [11:0] p);
        mk = '{kind: seg_kind_t'(k), initial_only: 1'b0, rate: r, amp: a, offset: o,
               start_ang: 12'h000, stop_ang: 12'h000, points: p};
    endfunction : mk

    // Square starts on its positive half, so the first point sits half an amplitude up.
    function automatic logic signed [23:0] sq_val(input logic signed [23:0] a,
                                                  input logic signed [23:0] o);
        sq_val = o + 24'((int'(a) * 32767) >>> 16);
    endfunction : sq_val

    task automatic wr(input segment_t s, input logic ok);
        seg_wr = 1'b1;
        seg_in = s;
        tick(1);
        // The answer stands for one cycle only, so it is looked at right after the edge.
        chk("seg_ack", 32'(seg_ack), 32'(ok));
        chk("seg_reject", 32'(seg_reject), 32'(!ok));
        seg_wr = 1'b0;
        tick(1);
    endtask : wr

    task automatic clr(input logic m);
        wave_clear = 1'b1;
        mode_sel = m;
        tick(1);
        wave_clear = 1'b0;
        tick(1);
        chk("wave_mode", 32'(wave_mode), 32'(m));
    endtask : clr

    // Start a run and wait, bounded, for the first point, two edges after the start edge.
    task automatic start();
        int n;
        n = 0;
        run_start = 1'b1;
        tick(1);
        run_start = 1'b0;
        tick(1);
        chk("output_enable", 32'(output_enable), 32'h1);
        while (setpoint_valid !== 1'b1 && n < 8) begin
            tick(1);
            n++;
        end
        if (n == 8) begin
            err_total++;
            end_sim();
        end
        chk("first point delay", 32'(n), 32'h1);
    endtask : start

    task automatic stop();
        run_stop = 1'b1;
        tick(1);
        run_stop = 1'b0;
        tick(1);
        chk("running", 32'(running), 32'h0);
        chk("output_enable", 32'(output_enable), 32'h0);
        chk("applied", 32'(applied), 32'h0);
    endtask : stop

    initial begin
        void'($urandom(32'h83cb75a8));
        tick(2);
        rst = 1'b0;
        chk("seg_total", 32'(seg_total), 32'h0);
        for (int k = 0; k < 6; k++) begin
            clr(1'b0);
            wr(mk(k, lo[k] - 17'h1, 0, 0, 12'h001), 1'b0);
            wr(mk(k, lo[k], 0, 0, 12'h001), 1'b1);
            wr(mk(k, hi[k], 0, 0, 12'h001), 1'b1);
            wr(mk(k, hi[k] + 17'h1, 0, 0, 12'h001), 1'b0);
        end
        clr(1'b0);
        wr(mk(4, 17'h00064, 24'h0007d1, 0, 12'h001), 1'b0);
        wr(mk(4, 17'h00064, 24'h0007d0, 0, 12'h001), 1'b1);
        wr(mk(5, 17'h00032, 0, 24'h0003e9, 12'h001), 1'b0);
        wr(mk(5, 17'h00032, 0, 24'hfffc18, 12'h001), 1'b1);
        clr(1'b1);
        for (int i = 0; i < 10; i++) begin
            wr(mk(5, 17'h00032, 0, 0, 12'h001), 1'b1);
        end
        wr(mk(5, 17'h00032, 0, 0, 12'h001), 1'b0);
        chk("seg_total", 32'(seg_total), 32'ha);
        clr(1'b0);
        wr(mk(5, 17'h00032, 0, 0, 12'hf5d), 1'b1);
        wr(mk(5, 17'h00032, 0, 0, 12'h001), 1'b0);
        // Random centre and swing, kept inside the limits so no clamping hides the shape.
        for (int k = 0; k < 6; k++) begin
            off = 24'($urandom_range(1000)) - 24'h0001f4;
            amp = 24'($urandom_range(900) + 100);
            clr(k[0]);
            wr(mk(k, (k == 5) ? 17'h00032 : 17'h00064, amp, off, 12'h004), 1'b1);
            start();
            case (k)
                0: chk("square", 32'(setpoint), 32'(sq_val(amp, off)));
                1: chk("pos ramp", 32'(setpoint < off), 32'h1);
                2: chk("neg ramp", 32'(setpoint > off), 32'h1);
                5: chk("level", 32'(setpoint), 32'(off));
                default: chk("centre", 32'(setpoint), 32'(off));
            endcase
            tick(1);
            chk("applied", 32'(applied), 32'(setpoint));
            stop();
        end
        // Two short sine arcs, both flagged initial; the last one must repeat anyway.
        amp = 24'h000190;
        off = 24'h000064;
        s0 = mk(4, SINE_FREQ_MAX, amp, off, 12'h001);
        s0.initial_only = 1'b1;
        s0.start_ang = ANG_QUARTER;
        s0.stop_ang = ANG_QUARTER + 12'h00a;
        s1 = s0;
        s1.start_ang = ANG_FULL - 12'h00a;
        s1.stop_ang = 12'h000;
        for (int c = 0; c < 2; c++) begin
            clr(1'b0);
            wr(s0, 1'b1);
            wr(s1, 1'b1);
            count_in = (c == 0) ? 10'h002 : 10'h000;
            run_start = 1'b1;
            tick(1);
            run_start = 1'b0;
            n = 0;
            pts = 0;
            while (running === 1'b1 && n < 3000) begin
                if (setpoint_valid === 1'b1) begin
                    // Only the first point sits on the crest; later passes play the last arc.
                    exp_v = (pts == 0) ? sq_val(amp, off) : off;
                    chk("arc point", 32'(setpoint), 32'(exp_v));
                    pts++;
                end
                tick(1);
                n++;
            end
            if (c == 0) begin
                if (n == 3000) begin
                    err_total++;
                    end_sim();
                end
                chk("pass points", 32'(pts), 32'h3);
                chk("output_enable", 32'(output_enable), 32'h0);
            end else begin
                chk("endless run", 32'(running), 32'h1);
                chk("endless points", 32'(pts > 3), 32'h1);
                stop();
            end
        end
        lim = '{24'h000064, 24'hfffc18};
        clr(1'b0);
        wr(mk(0, 17'h00064, 24'h0003e8, 0, 12'h004), 1'b1);
        start();
        chk("clamped", 32'(setpoint), 32'h00000064);
        stop();
        end_sim();
    end
endmodule : waveform_segment_sequencer_test
